// ===== inc/thermal_watchdog_pkg.sv
/*
  constants for the thermal watchdog compare block: pointer values,
  field positions, reset values and timing counts.
  assumes a 200 MHz system clock and an outside serial front end.
*/
// Functional notes
// (RL1) top nine reading bits give half-degree value
// (RL2) msbyte alone reads as whole degrees
// (RL3) compare limits after every finished conversion
// (RL4) limits hold nine msbs, two bytes
// (RL5) compare uses reading bits ten to two
// (RL6) limit read returns low seven bits zero
// (RL7) single byte limit read is harmless
// (RL8) only low five interval bits count
// (RL9) start sampling every interval times 100 ms
// (RL10) interval zero behaves as interval one
// (RL11) interval resets to one
// (RL12) conversion lasts 28 ms, then idle
// (RL13) alarm pin only pulls low
// (RL14) polarity bit two, reset active low
// (RL15) mode bit one, reset comparator
// (RL16) comparator: set above, release below
// (RL17) comparator ignores reads and shutdown
// (RL18) interrupt: latch event until any read
// (RL19) host keeps overheat above release
// (RL20) trip after 1, 2, 4, 6 faults
// (RL21) shutdown halts conversions, clears interrupt alarm
// (RL22) interrupt events alternate overheat then release
// (RL23) reading loaded left aligned, low bits zero
`default_nettype none
package thermal_watchdog_pkg;
  // -------------------------------------------------------------
  // pointer values
  // -------------------------------------------------------------
  localparam logic [2:0] PTR_TEMP    = 3'h0;
  localparam logic [2:0] PTR_CONF    = 3'h1;
  localparam logic [2:0] PTR_RELEASE = 3'h2;
  localparam logic [2:0] PTR_OVRHEAT = 3'h3;
  localparam logic [2:0] PTR_IDLE    = 3'h4;
  // -------------------------------------------------------------
  // configuration, reading and limit fields
  // -------------------------------------------------------------
  localparam int CONF_SHDN_BIT  = 0;
  localparam int CONF_MODE_BIT  = 1;
  localparam int CONF_POL_BIT   = 2;
  localparam int CONF_QUE_LSB   = 3;
  localparam int TEMP_LSB       = 5;
  localparam int LIMIT_LSB      = 7;
  // -------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------
  localparam logic [4:0]  CONF_RESET    = 5'h00;
  localparam logic [4:0]  IDLE_RESET    = 5'h01;
  localparam logic [10:0] TEMP_RESET    = 11'h000;
  localparam logic [8:0]  OVRHEAT_RESET = 9'h0A0;
  localparam logic [8:0]  RELEASE_RESET = 9'h096;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int CLK_MHZ        = 200;
  localparam int SAMPLE_UNIT_MS = 100;
  localparam int CONV_TIME_MS   = 28;
  localparam int SAMPLE_UNIT_CYC = SAMPLE_UNIT_MS * 1000 * CLK_MHZ;
  localparam int CONV_CYC        = CONV_TIME_MS * 1000 * CLK_MHZ;
endpackage : thermal_watchdog_pkg
`default_nettype wire

// ===== rtl/thermal_watchdog_compare.sv
/*
  thermal watchdog compare: reading, limits, interval pacing, alarm pin.
  assumes a serial front end that decodes the pointer and gives one
  strobe per register read or write, and a converter whose code is
  valid when the conversion window ends.
*/
`timescale 1ns/10ps
`default_nettype none
module thermal_watchdog_compare
  import thermal_watchdog_pkg::*;
#(
  parameter int UNIT_CYCLES = SAMPLE_UNIT_CYC,
  parameter int CONV_CYCLES = CONV_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [2:0]  reg_ptr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [10:0] adc_code,
  output logic             conv_busy,
  input  wire logic        alarm_pin_i,
  output logic             alarm_pin_o,
  output logic             alarm_pin_oe
);
  // -------------------------------------------------------------
  // parameter checks and types
  // -------------------------------------------------------------
  localparam int UW = $clog2(UNIT_CYCLES + 1);
  localparam int CW = $clog2(CONV_CYCLES + 1);

  if (UNIT_CYCLES < 2 || CONV_CYCLES < 1 || CONV_CYCLES >= UNIT_CYCLES) begin : g_bad
    $error("cycle counts out of range");
  end

  typedef struct packed {
    logic [10:0]   temp;
    logic [8:0]    ovr;
    logic [8:0]    rel;
    logic [4:0]    conf;
    logic [4:0]    idle;
    logic [UW-1:0] tick;
    logic [4:0]    units;
    logic [CW-1:0] conv;
    logic          busy;
    logic [2:0]    faults;
    logic          hunt_low;
    logic          alarm;
    logic          oe;
    logic          pin_lvl;
    logic [15:0]   rdata;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // -------------------------------------------------------------
  // decoding helpers
  // -------------------------------------------------------------
  function automatic logic [2:0] queue_len(input logic [1:0] code);
    case (code)
      2'h0:    queue_len = 3'h1;
      2'h1:    queue_len = 3'h2;
      2'h2:    queue_len = 3'h4;
      default: queue_len = 3'h6;
    endcase
  endfunction : queue_len

  function automatic logic [4:0] period_units(input logic [4:0] v);
    period_units = (v == 5'h00) ? 5'h01 : v;  // see RL10
  endfunction : period_units

  function automatic logic [15:0] read_word(input state_s s, input logic [2:0] p);
    case (p)
      PTR_TEMP:    read_word = {s.temp, 5'h00};  // see RL1 see RL2
      PTR_CONF:    read_word = {11'h000, s.conf};
      PTR_RELEASE: read_word = {s.rel, 7'h00};   // see RL6 see RL7
      PTR_OVRHEAT: read_word = {s.ovr, 7'h00};   // see RL6 see RL7
      PTR_IDLE:    read_word = {11'h000, s.idle};
      default:     read_word = 16'h0000;
    endcase
  endfunction : read_word

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  logic       shdn;
  logic       mode_int;
  logic       unit_end;
  logic       start;
  logic       conv_end;
  logic       fault;
  logic       trip;
  logic [8:0] reading9;
  logic [2:0] faults_inc;

  always_comb begin
    s_nxt      = s_r;
    shdn       = s_r.conf[CONF_SHDN_BIT];
    mode_int   = s_r.conf[CONF_MODE_BIT];
    unit_end   = 1'b0;
    start      = 1'b0;
    conv_end   = 1'b0;
    fault      = 1'b0;
    trip       = 1'b0;
    reading9   = adc_code[10:2];  // see RL5
    faults_inc = s_r.faults + 3'h1;

    // interval pacing; shutdown parks the counters
    if (shdn) begin  // see RL21
      s_nxt.tick  = '0;
      s_nxt.units = 5'h00;
      s_nxt.busy  = 1'b0;
      s_nxt.conv  = '0;
    end else begin
      unit_end = (s_r.tick == UW'(UNIT_CYCLES - 1));
      s_nxt.tick = unit_end ? '0 : s_r.tick + UW'(1);
      if (unit_end) begin  // see RL9
        if (s_r.units + 5'h01 >= period_units(s_r.idle)) begin
          s_nxt.units = 5'h00;
          start       = !s_r.busy;
        end else begin
          s_nxt.units = s_r.units + 5'h01;
        end
      end
      // a busy conversion skips an overlapping start
      if (start) begin  // see RL12
        s_nxt.busy = 1'b1;
        s_nxt.conv = CW'(CONV_CYCLES - 1);
      end else if (s_r.busy) begin
        if (s_r.conv == '0) begin
          conv_end   = 1'b1;
          s_nxt.busy = 1'b0;
        end else begin
          s_nxt.conv = s_r.conv - CW'(1);
        end
      end
    end

    // read strobe: capture word, clear a latched interrupt
    if (reg_rd) begin
      s_nxt.rdata = read_word(s_r, reg_ptr);
      if (mode_int) begin  // see RL18 see RL17
        s_nxt.alarm = 1'b0;
      end
    end

    // register writes
    if (reg_wr) begin
      case (reg_ptr)
        PTR_CONF: begin
          s_nxt.conf = reg_wdata[4:0];
          if (reg_wdata[CONF_SHDN_BIT] && reg_wdata[CONF_MODE_BIT]) begin  // see RL21
            s_nxt.alarm = 1'b0;
          end
        end
        PTR_RELEASE: s_nxt.rel  = reg_wdata[15:LIMIT_LSB];  // see RL4
        PTR_OVRHEAT: s_nxt.ovr  = reg_wdata[15:LIMIT_LSB];  // see RL4
        PTR_IDLE:    s_nxt.idle = reg_wdata[4:0];           // see RL8
        default: begin
        end
      endcase
    end

    // end of conversion: load reading, compare, fault queue
    if (conv_end) begin  // see RL3
      s_nxt.temp = adc_code;  // see RL23
      fault = s_r.hunt_low ? ($signed(reading9) < $signed(s_r.rel))
                           : ($signed(reading9) > $signed(s_r.ovr));
      if (!fault) begin
        s_nxt.faults = 3'h0;
      end else if (faults_inc >= queue_len(s_r.conf[CONF_QUE_LSB +: 2])) begin  // see RL20
        trip         = 1'b1;
        s_nxt.faults = 3'h0;
      end else begin
        s_nxt.faults = faults_inc;
      end
      if (trip) begin
        s_nxt.hunt_low = !s_r.hunt_low;  // see RL22
        // a trip beats a same-cycle clear by read
        s_nxt.alarm = mode_int ? 1'b1 : !s_r.hunt_low;  // see RL16 see RL18
      end
    end

    // open drain: pull low when the pin level must be low
    s_nxt.oe = s_nxt.alarm ^ s_nxt.conf[CONF_POL_BIT];  // see RL13 see RL14
    // data level tied low; a high level is left to the pull-up
    s_nxt.pin_lvl = 1'b0;  // see RL13
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r          <= '0;
      s_r.temp     <= TEMP_RESET;
      s_r.ovr      <= OVRHEAT_RESET;
      s_r.rel      <= RELEASE_RESET;
      s_r.conf     <= CONF_RESET;  // see RL14 see RL15
      s_r.idle     <= IDLE_RESET;  // see RL11
    end else begin
      s_r <= s_nxt;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign reg_rdata    = s_r.rdata;
  assign conv_busy    = s_r.busy;
  assign alarm_pin_o  = s_r.pin_lvl;  // see RL13
  assign alarm_pin_oe = s_r.oe;

  // pin readback is not needed; the level is ours or the pull-up's
  logic pin_seen;
  assign pin_seen = alarm_pin_i;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  chk_pin_polarity: assert property (  // see RL14
    @(posedge clk) disable iff (!reset_n)
    alarm_pin_oe == (s_r.alarm ^ s_r.conf[CONF_POL_BIT]))
    else $error("alarm pin drive does not follow alarm and polarity");

  chk_pin_low_only: assert property (  // see RL13
    @(posedge clk) disable iff (!reset_n)
    alarm_pin_o == 1'b0)
    else $error("alarm pin driven high");

  chk_limit_low_zero: assert property (  // see RL6
    @(posedge clk) disable iff (!reset_n)
    reg_rd && (reg_ptr == PTR_OVRHEAT || reg_ptr == PTR_RELEASE)
    |=> reg_rdata[6:0] == 7'h00)
    else $error("limit read low bits not zero");

  chk_temp_read: assert property (  // see RL1
    @(posedge clk) disable iff (!reset_n)
    reg_rd && reg_ptr == PTR_TEMP |=> reg_rdata == {$past(s_r.temp), 5'h00})
    else $error("reading word mismatch");

  chk_idle_high_zero: assert property (  // see RL8
    @(posedge clk) disable iff (!reset_n)
    reg_rd && reg_ptr == PTR_IDLE |=> reg_rdata[15:5] == 11'h000)
    else $error("interval read upper bits not zero");

  chk_int_read_clear: assert property (  // see RL18
    @(posedge clk) disable iff (!reset_n)
    reg_rd && mode_int && !conv_end && !reg_wr |=> !s_r.alarm)
    else $error("read did not clear interrupt alarm");

  chk_comp_read_hold: assert property (  // see RL17
    @(posedge clk) disable iff (!reset_n)
    !mode_int && !conv_end && !reg_wr |=> $stable(s_r.alarm))
    else $error("comparator alarm moved without a conversion");

  chk_shdn_no_conv: assert property (  // see RL21
    @(posedge clk) disable iff (!reset_n)
    shdn ##1 shdn |-> !conv_busy)
    else $error("conversion running in shutdown");

  chk_temp_load: assert property (  // see RL23
    @(posedge clk) disable iff (!reset_n)
    conv_end |=> s_r.temp == $past(adc_code))
    else $error("reading not loaded at conversion end");

  chk_conv_length: assert property (  // see RL12
    @(posedge clk) disable iff (!reset_n)
    $rose(conv_busy) && !shdn |-> conv_busy throughout (##1 1'b1))
    else $error("conversion window too short");

  chk_idle_reset: assert property (  // see RL11
    @(posedge clk)
    $rose(reset_n) |-> s_r.idle == IDLE_RESET)
    else $error("interval not reset to one");

  chk_shdn_int_clear: assert property (  // see RL21
    @(posedge clk) disable iff (!reset_n)
    reg_wr && reg_ptr == PTR_CONF && reg_wdata[CONF_SHDN_BIT] && reg_wdata[CONF_MODE_BIT]
    && !trip |=> !s_r.alarm)
    else $error("shutdown did not clear interrupt alarm");

  chk_int_trip_set: assert property (  // see RL18
    @(posedge clk) disable iff (!reset_n)
    trip && mode_int |=> s_r.alarm)
    else $error("interrupt trip did not raise alarm");

  chk_comp_trip: assert property (  // see RL16
    @(posedge clk) disable iff (!reset_n)
    trip && !mode_int |=> s_r.alarm == s_r.hunt_low)
    else $error("comparator alarm does not follow trip");

  chk_hunt_toggle: assert property (  // see RL22
    @(posedge clk) disable iff (!reset_n)
    trip |=> s_r.hunt_low != $past(s_r.hunt_low))
    else $error("trip direction did not alternate");

  chk_fault_clear: assert property (  // see RL20
    @(posedge clk) disable iff (!reset_n)
    conv_end && !fault |=> s_r.faults == 3'h0)
    else $error("fault count kept after a clean conversion");

  chk_fault_count: assert property (  // see RL20
    @(posedge clk) disable iff (!reset_n)
    conv_end && fault && !trip |=> s_r.faults == $past(s_r.faults) + 3'h1)
    else $error("fault count did not advance");

  chk_alarm_quiet: assert property (  // see RL3
    @(posedge clk) disable iff (!reset_n)
    !conv_end && !reg_rd && !reg_wr |=> $stable(s_r.alarm))
    else $error("alarm moved without conversion or access");

  chk_conv_start: assert property (  // see RL12
    @(posedge clk) disable iff (!reset_n)
    $rose(conv_busy) |-> s_r.conv == CW'(CONV_CYCLES - 1))
    else $error("conversion window loaded with wrong length");

  chk_conv_step: assert property (  // see RL12
    @(posedge clk) disable iff (!reset_n)
    conv_busy && !conv_end && !shdn |=> conv_busy && s_r.conv == $past(s_r.conv) - CW'(1))
    else $error("conversion window did not count down");

  chk_conv_stop: assert property (  // see RL12
    @(posedge clk) disable iff (!reset_n)
    conv_end |=> !conv_busy)
    else $error("conversion window did not close");

  chk_interval_floor: assert property (  // see RL10
    @(posedge clk) disable iff (!reset_n)
    unit_end && !s_r.busy && s_r.idle <= 5'h01 |-> start)
    else $error("short interval skipped a unit");

  chk_start_unit: assert property (  // see RL9
    @(posedge clk) disable iff (!reset_n)
    !unit_end |-> !start)
    else $error("conversion started off a unit boundary");

  chk_conf_read: assert property (  // see RL15
    @(posedge clk) disable iff (!reset_n)
    reg_rd && reg_ptr == PTR_CONF |=> reg_rdata == {11'h000, $past(s_r.conf)})
    else $error("configuration read mismatch");

  chk_rdata_hold: assert property (  // see RL7
    @(posedge clk) disable iff (!reset_n)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read word moved without a read");

  chk_oe_reset: assert property (  // see RL14
    @(posedge clk)
    $rose(reset_n) |-> !alarm_pin_oe)
    else $error("alarm pin pulled low out of reset");

  chk_limit_write: assert property (  // see RL4
    @(posedge clk) disable iff (!reset_n)
    reg_wr && reg_ptr == PTR_OVRHEAT |=> {s_r.ovr, 7'h00} == ($past(reg_wdata) & 16'hFF80))
    else $error("overheat limit write mismatch");

endmodule : thermal_watchdog_compare
`default_nettype wire

// ===== tb/host_model.sv
/* host model: register strobes and alarm pin pull-up.
   assumes the block's strobe port and one clock. */
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic        clk,
  output logic      [2:0]  reg_ptr,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        alarm_pin_oe,
  input  wire logic        alarm_pin_o,
  output logic             pin
);
  // driven level while enabled, pull-up otherwise
  assign pin = alarm_pin_oe ? alarm_pin_o : 1'b1;
  initial begin
    reg_ptr = 3'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  task wr(input logic [2:0] p, input logic [15:0] dat);
    @(posedge clk);
    #1;
    reg_ptr = p;
    reg_wdata = dat;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~dat; // released data must not echo the last word
  endtask : wr
  task rd(input logic [2:0] p, output logic [15:0] dat);
    @(posedge clk);
    #1;
    reg_ptr = p;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    @(posedge clk);
    #1;
    dat = reg_rdata;
  endtask : rd
endmodule : host_model
`default_nettype wire

// ===== tb/thermal_watchdog_compare_tb.sv
/* bench for the thermal watchdog compare block.
   assumes short unit and conversion counts and a pulled-up pin. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin tests_run++; if ((a)!==(b)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module thermal_watchdog_compare_tb;
  import thermal_watchdog_pkg::*;
  logic        clk, reset_n, reg_wr, reg_rd, conv_busy, pin_o, pin_oe, pin;
  logic [2:0]  reg_ptr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [10:0] adc_code;
  logic [8:0]  ovr, rel;
  logic [15:0] rst_tab [8] = '{16'h0000, 16'h0000, 16'h4B00, 16'h5000, 16'h0001,
    16'h0000, 16'h0000, 16'h0000};
  int          fail_count, tests_run, cyc, n, per, w, nq;
  // ---------------------------------------------
  // clock, dut, host
  // ---------------------------------------------
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  thermal_watchdog_compare #(.UNIT_CYCLES(100), .CONV_CYCLES(28)) dut_u (
    .clk(clk), .reset_n(reset_n), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_code(adc_code), .conv_busy(conv_busy), .alarm_pin_i(pin),
    .alarm_pin_o(pin_o), .alarm_pin_oe(pin_oe));
  host_model h (.clk(clk), .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarm_pin_oe(pin_oe), .alarm_pin_o(pin_o),
    .pin(pin));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic exp_pin(input logic act, input logic pol);
    return act ~^ pol;
  endfunction : exp_pin
  task test_done;
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done;
    end
  end
  task wait_conv;
    n = 0;
    while (conv_busy !== 1'b1 && n < 1000) begin @(posedge clk); #1; n++; end
    while (conv_busy !== 1'b0 && n < 1000) begin @(posedge clk); #1; n++; end
    repeat (2) @(posedge clk);
    #1;
  endtask : wait_conv
  task period;
    n = 0;
    while (conv_busy !== 1'b1 && n < 4000) begin @(posedge clk); #1; n++; end
    per = 0;
    w = 0;
    while (conv_busy === 1'b1 && per < 4000) begin @(posedge clk); #1; per++; w++; end
    while (conv_busy !== 1'b1 && per < 4000) begin @(posedge clk); #1; per++; end
  endtask : period
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    void'($urandom(91));
    reset_n = 1'b0;
    adc_code = 11'h000;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    `CHK(pin, 1'b1)
    for (int i = 0; i < 8; i++) begin
      h.rd(3'(i), d);
      `CHK(d, rst_tab[i])
    end
    period;
    period;
    `CHK(per, 100)
    `CHK(w, 28)
    h.wr(3'h4, 16'h00E0);
    h.rd(3'h4, d);
    `CHK(d, 16'h0000)
    period;
    period;
    `CHK(per, 100)
    h.wr(3'h4, 16'h0003);
    period;
    period;
    `CHK(per, 300)
    h.wr(3'h4, 16'h0001);
    ovr = 9'h040 + 9'($urandom_range(0, 63));
    rel = ovr - 9'h004;
    h.wr(3'h3, {ovr, 7'h7F});
    h.wr(3'h2, {rel, 7'h55});
    h.rd(3'h3, d);
    `CHK(d, {ovr, 7'h00})
    `CHK(d[15:8], ovr[8:1])
    h.rd(3'h2, d);
    `CHK(d, {rel, 7'h00})
    adc_code = {ovr, 2'b11};
    wait_conv;
    `CHK(pin, 1'b1)
    // each queue code: trip exactly on the last fault
    for (int q = 0; q < 4; q++) begin
      nq = (q == 0) ? 1 : (q == 1) ? 2 : (q == 2) ? 4 : 6;
      h.wr(3'h1, 16'(q << 3));
      adc_code = {ovr + 9'h001, 2'($urandom)};
      for (int i = 1; i <= nq; i++) begin
        wait_conv;
        `CHK(pin, exp_pin(i == nq, 1'b0))
      end
      h.rd(3'h0, d);
      `CHK(d, {adc_code, 5'h00})
      `CHK(d[15:7], adc_code[10:2])
      `CHK(d[15:8], adc_code[10:3])
      h.wr(3'h1, 16'(q << 3 | 1));
      `CHK(pin, 1'b0)
      h.wr(3'h1, 16'(q << 3));
      adc_code = {rel - 9'h001, 2'($urandom)};
      repeat (nq) wait_conv;
      `CHK(pin, 1'b1)
    end
    h.wr(3'h1, 16'h0006);
    adc_code = {ovr + 9'h001, 2'b00};
    wait_conv;
    `CHK(pin, 1'b1)
    wait_conv;
    `CHK(pin, 1'b1)
    h.rd(3'h4, d);
    `CHK(pin, 1'b0)
    wait_conv;
    `CHK(pin, 1'b0)
    adc_code = {rel - 9'h001, 2'b00};
    wait_conv;
    `CHK(pin, 1'b1)
    h.rd(3'h1, d);
    `CHK(d, 16'h0006)
    adc_code = {ovr + 9'h001, 2'b00};
    wait_conv;
    `CHK(pin, 1'b1)
    h.wr(3'h1, 16'h0007);
    `CHK(pin, 1'b0)
    n = 0;
    repeat (300) begin @(posedge clk); #1; if (conv_busy !== 1'b0) n++; end
    `CHK(n, 0)
    `CHK(pin_o, 1'b0)
    test_done;
  end
endmodule : thermal_watchdog_compare_tb
`default_nettype wire
